// ===== hdl/ricf_chg.sv
// pulses for one cycle when a level toggles in either direction
module ricf_chg #(
  parameter int WIDTH = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] change_pulse
);
  import ricf_pkg::*;

  // samples to skip after reset: the synchroniser shows its reset zeros for two of them
  localparam logic [1:0] SETTLED = 2'h3;

  // whole state of the change detector
  typedef struct packed {
    logic [1:0] settle_cnt;     // samples taken since reset, saturating
    logic [WIDTH-1:0] prev;     // level seen at the previous sample
    logic [WIDTH-1:0] pulse;    // one-cycle change pulses
  } ricf_chg_state_t;

  ricf_chg_state_t st;
  ricf_chg_state_t next_st;

  // compare against the previous level only once both sides hold real pin levels,
  // so a high input at reset release does not look like a change
  always_comb begin
    next_st = st;
    next_st.prev = level_in;
    if (st.settle_cnt != SETTLED) begin
      // still priming
      next_st.settle_cnt = st.settle_cnt + 2'h1;
    end
    next_st.pulse = (st.settle_cnt == SETTLED) ? (level_in ^ st.prev) : '0;
  end

  // register the state, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign change_pulse = st.pulse;

endmodule // ricf_chg

// ===== hdl/ricf_pkg.sv
// shared constants for the reference input change flag block
package ricf_pkg;

  // bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  typedef logic [ADDR_W-1:0] ricf_addr_t;
  typedef logic [DATA_W-1:0] ricf_data_t;
  typedef logic [3:0] ricf_strb_t;
  typedef logic [1:0] ricf_resp_t;

  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_TEST_CTRL = 6'h04;
  localparam logic [5:0] IDX_FLAGS_LOW = 6'h05;
  localparam logic [5:0] IDX_IRQ_EN = 6'h06;
  localparam logic [5:0] IDX_FLAGS_CLR = 6'h07;
  localparam logic [5:0] IDX_VALID_NOW = 6'h08;

  // flag byte layout
  localparam int POS_REF3 = 7;
  localparam int POS_REF2 = 3;
  localparam int POS_REF1 = 2;
  localparam logic [7:0] FLAG_MASK = 8'h8C;
  localparam logic [7:0] FLAGS_LOW_RESET = 8'hFF;
  localparam logic [7:0] UNUSED_READ = 8'h73;

  // number of reference inputs watched
  localparam int NUM_REF = 3;
  localparam logic [NUM_REF-1:0] FLAG_RESET = 3'h7;
  localparam logic [NUM_REF-1:0] IRQ_EN_RESET = 3'h0;

  // test control register
  localparam logic [1:0] TEST_CTRL_RESET = 2'h0;

  // response codes
  localparam ricf_resp_t RESP_OKAY = 2'h0;
  localparam ricf_resp_t RESP_SLVERR = 2'h2;

endpackage : ricf_pkg

// ===== hdl/ricf_sync.sv
// two flip-flop synchroniser for a group of level inputs
module ricf_sync #(
  parameter int WIDTH = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import ricf_pkg::*;

  // whole state of the synchroniser
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ricf_sync_state_t;

  ricf_sync_state_t st;
  ricf_sync_state_t next_st;

  // first stage is read only by the second stage
  always_comb begin
    next_st = st;
    next_st.meta = async_in;
    next_st.stable = st.meta;
  end

  // register the state, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;

endmodule // ricf_sync

// ===== hdl/ricf_top.sv
// Register access over AXI4-Lite is this design's own decision.
module ricf_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // validity levels of the three reference inputs, bit 0 is input one
  input wire logic [2:0] ref_valid,
  // write address channel
  input wire logic awvalid,
  output logic awready,
  input wire ricf_pkg::ricf_addr_t awaddr,
  input wire logic [2:0] awprot,
  // write data channel
  input wire logic wvalid,
  output logic wready,
  input wire ricf_pkg::ricf_data_t wdata,
  input wire ricf_pkg::ricf_strb_t wstrb,
  // write response channel
  output logic bvalid,
  input wire logic bready,
  output ricf_pkg::ricf_resp_t bresp,
  // read address channel
  input wire logic arvalid,
  output logic arready,
  input wire ricf_pkg::ricf_addr_t araddr,
  input wire logic [2:0] arprot,
  // read data channel
  output logic rvalid,
  input wire logic rready,
  output ricf_pkg::ricf_data_t rdata,
  output ricf_pkg::ricf_resp_t rresp,
  // level interrupt, high while an enabled flag is set
  output logic irq
);
  import ricf_pkg::*;

  // whole state of the block
  typedef struct packed {
    logic aw_full;           // write address held
    ricf_addr_t aw_addr;     // held write address
    logic w_full;            // write data held
    ricf_data_t w_data;      // held write data
    ricf_strb_t w_strb;      // held byte enables
    logic awready;           // registered ready for addresses
    logic wready;            // registered ready for data
    logic bvalid;            // write response pending
    ricf_resp_t bresp;       // write response code
    logic arready;           // registered ready for read addresses
    logic rvalid;            // read data pending
    ricf_data_t rdata;       // read data
    ricf_resp_t rresp;       // read response code
    logic [NUM_REF-1:0] flags;   // latched change flags, input one first
    logic [NUM_REF-1:0] irq_en;  // interrupt enables, same order
    logic [1:0] test_ctrl;   // test control bits, no effect on logic
    logic irq;               // registered interrupt line
  } ricf_state_t;

  ricf_state_t st;
  ricf_state_t next_st;

  // synchronised validity levels
  logic [NUM_REF-1:0] valid_sync;
  // one-cycle pulses on each validity change
  logic [NUM_REF-1:0] valid_change;

  // map a byte address to a register index; flags misaligned addresses
  function automatic logic [6:0] decode_addr(input ricf_addr_t addr);
    logic [6:0] res;
    res = {1'b0, addr[7:2]};
    if (addr[1:0] != 2'h0) begin
      res[6] = 1'b1;
    end
    return res;
  endfunction

  // place the three flags at their byte positions
  function automatic logic [7:0] spread_flags(input logic [NUM_REF-1:0] f);
    logic [7:0] res;
    res = 8'h00;
    res[POS_REF1] = f[0];
    res[POS_REF2] = f[1];
    res[POS_REF3] = f[2];
    return res;
  endfunction

  // gather the three flag positions out of a written byte
  function automatic logic [NUM_REF-1:0] gather_flags(input logic [7:0] b);
    return {b[POS_REF3], b[POS_REF2], b[POS_REF1]};
  endfunction

  // validity levels come from outside this clock domain
  ricf_sync #(
    .WIDTH(NUM_REF)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .async_in(ref_valid),
    .sync_out(valid_sync)
  );

  // detect changes in either direction
  ricf_chg #(
    .WIDTH(NUM_REF)
  ) u_chg (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .level_in(valid_sync),
    .change_pulse(valid_change)
  );

  // next-state logic for the bus slave, flags and interrupt
  always_comb begin
    logic [6:0] widx;
    logic [6:0] ridx;
    logic [NUM_REF-1:0] clr;
    logic do_write;
    logic wr_lane0;
    widx = 7'h00;
    ridx = 7'h00;
    clr = '0;
    do_write = 1'b0;
    wr_lane0 = 1'b0;
    next_st = st;

    // take a write address when offered and ready
    if (awvalid && st.awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = awaddr;
    end

    // take write data when offered and ready, in either order
    if (wvalid && st.wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
    end

    // retire a taken write response
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end

    // perform the write once address and data are both held and no write response is pending
    if (st.aw_full && st.w_full && !st.bvalid) begin
      do_write = 1'b1;
      widx = decode_addr(st.aw_addr);
      wr_lane0 = st.w_strb[0];
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      unique case (widx)
        {1'b0, IDX_TEST_CTRL}: begin
          // test bits kept as written
          if (wr_lane0) begin
            next_st.test_ctrl = st.w_data[1:0];
          end
        end
        {1'b0, IDX_FLAGS_LOW}, {1'b0, IDX_FLAGS_CLR}: begin
          if (wr_lane0) begin
            clr = gather_flags(st.w_data[7:0]);
          end
        end
        {1'b0, IDX_IRQ_EN}: begin
          // enables share the flag layout
          if (wr_lane0) begin
            next_st.irq_en = gather_flags(st.w_data[7:0]);
          end
        end
        {1'b0, IDX_VALID_NOW}: begin
          // read-only register, write ignored
          next_st.bresp = RESP_OKAY;
        end
        default: begin
          // unmapped or misaligned address
          next_st.bresp = RESP_SLVERR;
        end
      endcase
    end

    // retire a taken read response
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end

    // answer a read address one cycle after it is taken
    if (arvalid && st.arready) begin
      ridx = decode_addr(araddr);
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = '0;
      unique case (ridx)
        {1'b0, IDX_TEST_CTRL}: begin
          // test control bits read back
          next_st.rdata[1:0] = st.test_ctrl;
        end
        {1'b0, IDX_FLAGS_LOW}: begin
          next_st.rdata[7:0] = spread_flags(st.flags) | UNUSED_READ;
        end
        {1'b0, IDX_IRQ_EN}: begin
          // enable register readback
          next_st.rdata[7:0] = spread_flags(st.irq_en);
        end
        {1'b0, IDX_FLAGS_CLR}: begin
          // write-only register reads zero
          next_st.rdata = '0;
        end
        {1'b0, IDX_VALID_NOW}: begin
          // present validity of each input
          next_st.rdata[7:0] = spread_flags(valid_sync);
        end
        default: begin
          // unmapped or misaligned address
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end

    // flag update: a change in the clearing cycle keeps the flag set
    // reference three, two and one flags
    next_st.flags[2] = (st.flags[2] & ~clr[2]) | valid_change[2];
    next_st.flags[1] = (st.flags[1] & ~clr[1]) | valid_change[1];
    next_st.flags[0] = (st.flags[0] & ~clr[0]) | valid_change[0];

    next_st.irq = |(next_st.flags & next_st.irq_en);

    // readies follow the holding state, so they come from flip-flops
    next_st.awready = !next_st.aw_full;
    next_st.wready = !next_st.w_full;
    next_st.arready = !next_st.rvalid;

    // the write flag is only informative here
    if (!do_write) begin
      next_st.bresp = next_st.bresp;
    end
  end

  // register the state, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.flags <= FLAG_RESET;
      st.irq_en <= IRQ_EN_RESET;
      st.test_ctrl <= TEST_CTRL_RESET;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.bresp <= RESP_OKAY;
      st.rresp <= RESP_OKAY;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign irq = st.irq;

endmodule // ricf_top

// ===== tb/ricf_chk.sv
// bus and status checks seen from the top ports
module ricf_chk import ricf_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire ricf_resp_t bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire ricf_addr_t araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire ricf_data_t rdata,
  input wire ricf_resp_t rresp,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // address of the read in flight
  ricf_addr_t rd_addr;
  always_ff @(posedge aclk) begin
    if (arvalid && arready) begin
      rd_addr <= araddr;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  // read address taken
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  property p_wr_lat; s_wr_take |-> ##2 bvalid; endproperty
  property p_rd_lat; s_rd_take |=> rvalid; endproperty
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
  property p_ar_block; rvalid |-> !arready; endproperty
  property p_unused; rvalid && rd_addr == 8'h14 |-> rdata[6:4] == 3'h7 && rdata[1:0] == 2'h3;
  endproperty
  property p_clr_rd; rvalid && rd_addr == 8'h1C |-> rdata == 32'h0; endproperty
  property p_err; rvalid && rd_addr == 8'h40 |-> rresp == RESP_SLVERR; endproperty
  property p_irq_rst; $rose(aresetn) |-> !irq; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("late write response");
  a_rd_lat: assert property (p_rd_lat) else $error("late read data");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  a_unused: assert property (p_unused) else $error("unused status bits wrong");
  a_clr_rd: assert property (p_clr_rd) else $error("clear alias not zero");
  a_err: assert property (p_err) else $error("unmapped read not refused");
  a_irq_rst: assert property (p_irq_rst) else $error("irq high out of reset");
endmodule // ricf_chk

bind ricf_top ricf_chk ricf_chk_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));

// ===== tb/tb_top.sv
// register level bench with a byte model of flags and enables
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ricf_pkg::*;
`define CHK(nm, g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); \
  end \
end
  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [2:0] ref_valid;
  ricf_addr_t awaddr, araddr;
  ricf_data_t wdata, rdata;
  ricf_strb_t wstrb;
  ricf_resp_t bresp, rresp;
  int num_errors, n_compared, k;
  integer seed;
  // model of flag byte, enable byte and a random value
  logic [7:0] flags, en, m;
  ricf_top ricf_top_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .ref_valid(ref_valid),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq));
  // 200 MHz clock
  always #2.5 aclk = ~aclk;
  // verdict and end of run
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one write, address and data offered together
  task automatic wr(input ricf_addr_t a, input logic [7:0] d, input ricf_resp_t er);
    logic pa, pw, pb;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pb) begin
      @(posedge aclk);
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        pb = 1'b0;
        bready <= 1'b0;
        `CHK("bresp", bresp, er)
      end
    end
    // let an edge pass so a following call never re-raises a strobe in this step
    @(posedge aclk);
  endtask
  // one read, compared under a mask
  task automatic rd(input ricf_addr_t a, input logic [7:0] e, input ricf_data_t mk,
                    input ricf_resp_t er);
    logic pa, pr;
    pa = 1'b1;
    pr = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (pr) begin
      @(posedge aclk);
      if (pa && arready) begin
        pa = 1'b0;
        arvalid <= 1'b0;
      end else if (rvalid) begin
        pr = 1'b0;
        rready <= 1'b0;
        `CHK("rdata", rdata & mk, {24'h0, e} & mk)
        `CHK("rresp", rresp, er)
      end
    end
    // let an edge pass so a following call never re-raises a strobe in this step
    @(posedge aclk);
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {ref_valid, awaddr, araddr, wdata} = '0;
    ce = 1'b1;
    wstrb = 4'hF;
    seed = 1431;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h14, 8'hFF, 32'hFFFFFFFF, RESP_OKAY);
    rd(8'h18, 8'h00, {24'h0, FLAG_MASK}, RESP_OKAY);
    wr(8'h14, 8'h73, RESP_OKAY);
    rd(8'h14, 8'hFF, 32'hFFFFFFFF, RESP_OKAY);
    // a write without byte lane zero must leave the flags alone
    wstrb <= 4'hE;
    wr(8'h14, 8'hFF, RESP_OKAY);
    wstrb <= 4'hF;
    rd(8'h14, 8'hFF, 32'hFFFFFFFF, RESP_OKAY);
    wr(8'h14, 8'hFF, RESP_OKAY);
    flags = 8'h00;
    en = 8'h00;
    rd(8'h14, UNUSED_READ, 32'hFFFFFFFF, RESP_OKAY);
    wr(8'h10, 8'h00, RESP_OKAY);
    rd(8'h10, 8'h00, 32'hFFFFFFFF, RESP_OKAY);
    wr(8'h40, 8'hFF, RESP_SLVERR);
    rd(8'h40, 8'h00, 32'h0, RESP_SLVERR);
    rd(8'h1C, 8'h00, 32'hFFFFFFFF, RESP_OKAY);
    $display("test fixed done");
    // random edges, enables and clears
    for (int i = 0; i < 24; i++) begin
      k = $unsigned($random(seed)) % 3;
      m = $random(seed);
      ref_valid[k] <= ~ref_valid[k];
      repeat (8) @(posedge aclk);
      flags[k == 0 ? POS_REF1 : k == 1 ? POS_REF2 : POS_REF3] = 1'b1;
      rd(8'h14, flags | UNUSED_READ, 32'hFFFFFFFF, RESP_OKAY);
      // present validity in the flag layout
      rd(8'h20, {ref_valid[2], 3'h0, ref_valid[1], ref_valid[0], 2'h0}, 32'hFFFFFFFF,
         RESP_OKAY);
      wr(8'h18, m, RESP_OKAY);
      en = m & FLAG_MASK;
      rd(8'h18, en, {24'h0, FLAG_MASK}, RESP_OKAY);
      `CHK("irq", irq, |(flags & en))
      m = $random(seed);
      wr(i[0] ? 8'h1C : 8'h14, m, RESP_OKAY);
      flags = flags & ~m;
      rd(8'h14, flags | UNUSED_READ, 32'hFFFFFFFF, RESP_OKAY);
      `CHK("irq", irq, |(flags & en))
    end
    $display("test random done");
    // second reset in mid-run restores all flags and clears the enables
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    flags = FLAGS_LOW_RESET;
    en = 8'h00;
    rd(8'h14, flags, 32'hFFFFFFFF, RESP_OKAY);
    rd(8'h18, en, {24'h0, FLAG_MASK}, RESP_OKAY);
    `CHK("irq", irq, 1'b0)
    $display("test reset done");
    report_and_stop();
  end
endmodule // tb_top
